// ---- core/xms_defines.svh ----
`ifndef XMS_DEFINES_SVH
`define XMS_DEFINES_SVH
// register port
`define XMS_DW 32
`define XMS_RA_W 8
`define XMS_R_CFG 8'h00
`define XMS_R_ADDR 8'h04
`define XMS_R_WDAT 8'h08
`define XMS_R_CMD 8'h0C
`define XMS_R_STAT 8'h10
`define XMS_R_RDAT 8'h14
// command word and status bits
`define XMS_CMD_WR 0
`define XMS_CMD_BE_LO 1
`define XMS_CMD_BE_HI 2
`define XMS_ST_BUSY 0
`define XMS_ST_FULL 1
`define XMS_ST_EMPTY 2
`define XMS_ST_RVAL 3
`define XMS_ST_OVF 4
// timing configuration fields
`define XMS_CFG_W 15
`define XMS_CFG_RST 15'h0000
`define XMS_F_AE_HI 14
`define XMS_F_AE_LO 12
`define XMS_B_HOLD 10
`define XMS_B_RDH 9
`define XMS_B_WRH 8
`define XMS_F_WR_HI 7
`define XMS_F_WR_LO 4
`define XMS_F_RD_HI 3
`define XMS_F_RD_LO 0
// phase counts, in ref_clk ticks; one bus clock is two ticks
`define XMS_CNT_W 6
`define XMS_CNT_ZERO 6'h00
`define XMS_CNT_ONE 6'h01
`define XMS_HALF 6'h01
`define XMS_TPC 6'h02
// external bus widths and queue depth
`define XMS_AD_W 16
`define XMS_AW 18
`define XMS_BE_W 2
`define XMS_FIFO_D 8
`endif

// ---- core/xms_pkg.sv ----
`default_nettype none
`include "xms_defines.svh"
package xms_pkg;
	typedef enum logic [5:0] {
		S_IDLE = 6'h01,
		S_SEL = 6'h02,
		S_ALE = 6'h04,
		S_GAP = 6'h08,
		S_STRB = 6'h10,
		S_POST = 6'h20
	} xms_state_t;

	typedef struct packed {
		logic [`XMS_RA_W-1:0] addr;
		logic [`XMS_DW-1:0] wdata;
		logic wr;
		logic rd;
	} xms_bus_t;

	typedef struct packed {
		logic wr;
		logic [`XMS_BE_W-1:0] be;
		logic [`XMS_AW-1:0] addr;
		logic [`XMS_AD_W-1:0] data;
	} xms_req_t;

	typedef struct packed {
		logic memory_select_n;
		logic address_latch_enable;
		logic rd_n;
		logic wr_n;
		logic [`XMS_BE_W-1:0] byte_lane_enables_n;
		logic [`XMS_AW-`XMS_AD_W-1:0] addr_hi;
		logic [`XMS_AD_W-1:0] ad_out;
		logic ad_oe_n;
	} xms_pins_t;

	localparam xms_pins_t XMS_PINS_IDLE = '{memory_select_n: 1'b1, address_latch_enable: 1'b0, rd_n: 1'b1,
		wr_n: 1'b1, byte_lane_enables_n: '1, addr_hi: '0, ad_out: '0, ad_oe_n: 1'b1};

	function automatic logic [`XMS_CNT_W-1:0] xms_ale_t(input logic [`XMS_CFG_W-1:0] c);
		return ({3'h0, c[`XMS_F_AE_HI:`XMS_F_AE_LO]} + `XMS_CNT_ONE) * `XMS_TPC;
	endfunction : xms_ale_t

	function automatic logic [`XMS_CNT_W-1:0] xms_hold_t(input logic [`XMS_CFG_W-1:0] c);
		return `XMS_HALF + (c[`XMS_B_HOLD] ? `XMS_CNT_ZERO : `XMS_TPC);
	endfunction : xms_hold_t

	function automatic logic [`XMS_CNT_W-1:0] xms_gap_t(input logic [`XMS_CFG_W-1:0] c, input logic wr);
		return xms_hold_t(c) + ((wr ? c[`XMS_B_WRH] : c[`XMS_B_RDH]) ? `XMS_CNT_ZERO : `XMS_TPC);
	endfunction : xms_gap_t

	function automatic logic [`XMS_CNT_W-1:0] xms_strb_t(input logic [`XMS_CFG_W-1:0] c, input logic wr);
		return ({2'h0, wr ? c[`XMS_F_WR_HI:`XMS_F_WR_LO] : c[`XMS_F_RD_HI:`XMS_F_RD_LO]} + `XMS_CNT_ONE) * `XMS_TPC;
	endfunction : xms_strb_t

	function automatic logic [`XMS_CNT_W-1:0] xms_dhold_t(input logic [`XMS_CFG_W-1:0] c);
		return c[`XMS_B_WRH] ? `XMS_CNT_ZERO : `XMS_TPC;
	endfunction : xms_dhold_t

	function automatic logic [`XMS_CNT_W-1:0] xms_post_t(input logic [`XMS_CFG_W-1:0] c, input logic wr);
		return wr ? xms_dhold_t(c) + `XMS_TPC : `XMS_TPC;
	endfunction : xms_post_t
endpackage : xms_pkg
`default_nettype wire

// ---- core/xms_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module xms_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	localparam int CW = $clog2(D + 1);

	// pointers wrap naturally, so depth must be a power of two
	logic [W-1:0] mem [D];
	logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic rdy_q, rdy_d, push, pop;

	assign push = in_valid && rdy_q;
	assign pop = out_valid && out_ready;
	assign in_ready = rdy_q;
	assign out_valid = cnt_q != '0;
	assign out_data = mem[rp_q];

	always_comb begin
		wp_d = push ? wp_q + 1'b1 : wp_q;
		rp_d = pop ? rp_q + 1'b1 : rp_q;
		cnt_d = cnt_q + CW'(push) - CW'(pop);
		rdy_d = cnt_d != CW'(D);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			rdy_q <= 1'b1;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
			rdy_q <= rdy_d;
		end
	end

	// storage needs no reset; out_valid guards stale words
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_q] <= in_data;
		end
	end
endmodule : xms_fifo
`default_nettype wire

// ---- core/xms_phase_cnt.sv ----
`timescale 1ns/1ps
`default_nettype none
module xms_phase_cnt #(
	parameter int W = 6
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// phase length in ticks, at least one
	input wire logic load,
	input wire logic [W-1:0] load_val,
	// high during the final tick of the phase
	output logic last
);
	logic [W-1:0] cnt_q, cnt_d;

	assign last = cnt_q == W'(1);

	always_comb begin
		if (load) begin
			cnt_d = load_val;
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - 1'b1;
		end else begin
			cnt_d = cnt_q;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule : xms_phase_cnt
`default_nettype wire

// ---- core/xms_seq.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "xms_defines.svh"
// What this block does
// - latch enable lasts address field plus one
// - write strobe delay follows bits ten, eight
// - write strobe width is field plus one
// - data hold and select release after write
// - read strobe delay follows bits ten, nine
// - read strobe width is field plus one
module xms_seq (
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// register port
	input wire xms_pkg::xms_bus_t bus,
	output logic [`XMS_DW-1:0] bus_rdata_q,
	// command queue back-pressure
	output logic cmd_ready,
	// external memory pins
	output var xms_pkg::xms_pins_t pins_q,
	input wire logic [`XMS_AD_W-1:0] ad_in
);
	import xms_pkg::*;

	xms_state_t state_q, state_d;
	logic [`XMS_CFG_W-1:0] ext_bus_timing_config_q, ext_bus_timing_config_d, act_q, act_d;
	logic [`XMS_AW-1:0] addr_q, addr_d;
	logic [`XMS_AD_W-1:0] wdat_q, wdat_d, rdat_q, rdat_d;
	xms_req_t cur_q, cur_d, f_in, f_out;
	logic rval_q, rval_d, ovf_q, ovf_d;
	logic [`XMS_DW-1:0] bus_rdata_d;
	logic push, pop, f_valid, ph_last, ph_ld, cap;
	logic [`XMS_CNT_W-1:0] ph_val, el_q, el_d;
	xms_pins_t pins_d;
	logic adr_q, adr_d, bea_q, bea_d;

	// requests queue here so software can post several cycles ahead
	xms_fifo #(.W($bits(xms_req_t)), .D(`XMS_FIFO_D)) u_fifo (
		.clk(ref_clk),
		.arst_n(arst_n),
		.in_valid(push),
		.in_ready(cmd_ready),
		.in_data(f_in),
		.out_valid(f_valid),
		.out_ready(pop),
		.out_data(f_out)
	);

	xms_phase_cnt #(.W(`XMS_CNT_W)) u_phase (
		.clk(ref_clk),
		.arst_n(arst_n),
		.load(ph_ld),
		.load_val(ph_val),
		.last(ph_last)
	);

	// register port
	always_comb begin
		ext_bus_timing_config_d = ext_bus_timing_config_q;
		addr_d = addr_q;
		wdat_d = wdat_q;
		rdat_d = rdat_q;
		rval_d = rval_q;
		ovf_d = ovf_q;
		push = 1'b0;
		bus_rdata_d = '0;
		f_in = '{wr: bus.wdata[`XMS_CMD_WR], be: bus.wdata[`XMS_CMD_BE_HI:`XMS_CMD_BE_LO], addr: addr_q, data: wdat_q};
		if (bus.wr) begin
			case (bus.addr)
				`XMS_R_CFG: ext_bus_timing_config_d = bus.wdata[`XMS_CFG_W-1:0];
				`XMS_R_ADDR: addr_d = bus.wdata[`XMS_AW-1:0];
				`XMS_R_WDAT: wdat_d = bus.wdata[`XMS_AD_W-1:0];
				`XMS_R_CMD: push = 1'b1;
				`XMS_R_STAT: begin
					if (bus.wdata[`XMS_ST_OVF]) begin
						ovf_d = 1'b0;
					end
				end
				default: ;
			endcase
		end
		if (bus.rd) begin
			case (bus.addr)
				`XMS_R_CFG: bus_rdata_d[`XMS_CFG_W-1:0] = ext_bus_timing_config_q;
				`XMS_R_ADDR: bus_rdata_d[`XMS_AW-1:0] = addr_q;
				`XMS_R_WDAT: bus_rdata_d[`XMS_AD_W-1:0] = wdat_q;
				`XMS_R_STAT: begin
					bus_rdata_d[`XMS_ST_BUSY] = state_q != S_IDLE;
					bus_rdata_d[`XMS_ST_FULL] = !cmd_ready;
					bus_rdata_d[`XMS_ST_EMPTY] = !f_valid;
					bus_rdata_d[`XMS_ST_RVAL] = rval_q;
					bus_rdata_d[`XMS_ST_OVF] = ovf_q;
				end
				`XMS_R_RDAT: begin
					bus_rdata_d[`XMS_AD_W-1:0] = rdat_q;
					rval_d = 1'b0;
				end
				default: ;
			endcase
		end
		// sets come last so an event in the clearing cycle survives
		if (push && !cmd_ready) begin
			ovf_d = 1'b1;
		end
		if (cap) begin
			rdat_d = ad_in;
			rval_d = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ext_bus_timing_config_q <= `XMS_CFG_RST;
			addr_q <= '0;
			wdat_q <= '0;
			rdat_q <= '0;
			rval_q <= 1'b0;
			ovf_q <= 1'b0;
			bus_rdata_q <= '0;
		end else begin
			ext_bus_timing_config_q <= ext_bus_timing_config_d;
			addr_q <= addr_d;
			wdat_q <= wdat_d;
			rdat_q <= rdat_d;
			rval_q <= rval_d;
			ovf_q <= ovf_d;
			bus_rdata_q <= bus_rdata_d;
		end
	end

	// cycle sequencer; timing is latched per cycle so a config write never tears one
	always_comb begin
		state_d = state_q;
		act_d = act_q;
		cur_d = cur_q;
		pop = 1'b0;
		ph_ld = 1'b0;
		ph_val = `XMS_HALF;
		cap = 1'b0;
		case (state_q)
			S_IDLE: begin
				// wait for select to read high so back-to-back cycles keep a turnaround
				if (f_valid && pins_q.memory_select_n) begin
					pop = 1'b1;
					cur_d = f_out;
					act_d = ext_bus_timing_config_q;
					state_d = S_SEL;
					ph_ld = 1'b1;
					ph_val = `XMS_HALF;
				end
			end
			S_SEL: if (ph_last) begin
				state_d = S_ALE;
				ph_ld = 1'b1;
				ph_val = xms_ale_t(act_q);
			end
			S_ALE: if (ph_last) begin
				state_d = S_GAP;
				ph_ld = 1'b1;
				ph_val = xms_gap_t(act_q, cur_q.wr);
			end
			S_GAP: if (ph_last) begin
				state_d = S_STRB;
				ph_ld = 1'b1;
				ph_val = xms_strb_t(act_q, cur_q.wr);
			end
			S_STRB: if (ph_last) begin
				state_d = S_POST;
				ph_ld = 1'b1;
				ph_val = xms_post_t(act_q, cur_q.wr);
			end
			S_POST: begin
				// sampled on the edge that raises the read strobe; the memory holds past it
				cap = !cur_q.wr && el_q == `XMS_CNT_ZERO;
				if (ph_last) begin
					state_d = S_IDLE;
				end
			end
			default: state_d = S_IDLE;
		endcase
		el_d = ph_ld ? `XMS_CNT_ZERO : el_q + `XMS_CNT_ONE;
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= S_IDLE;
			act_q <= `XMS_CFG_RST;
			cur_q <= '0;
			el_q <= `XMS_CNT_ZERO;
		end else begin
			state_q <= state_d;
			act_q <= act_d;
			cur_q <= cur_d;
			el_q <= el_d;
		end
	end

	// pins lag the state by one tick, uniformly, so all spacings hold
	always_comb begin
		pins_d = XMS_PINS_IDLE;
		adr_d = 1'b0;
		bea_d = 1'b0;
		if (state_q != S_IDLE) begin
			pins_d.memory_select_n = 1'b0;
			pins_d.addr_hi = cur_q.addr[`XMS_AW-1:`XMS_AD_W];
			pins_d.address_latch_enable = state_q == S_ALE;
			adr_d = state_q == S_SEL || state_q == S_ALE || (state_q == S_GAP && el_q < xms_hold_t(act_q));
			bea_d = (state_q == S_GAP && el_q >= `XMS_HALF) || state_q == S_STRB || state_q == S_POST;
			if (bea_d) begin
				pins_d.byte_lane_enables_n = ~cur_q.be;
			end
			pins_d.wr_n = !(state_q == S_STRB && cur_q.wr);
			pins_d.rd_n = !(state_q == S_STRB && !cur_q.wr);
			if (adr_d) begin
				pins_d.ad_out = cur_q.addr[`XMS_AD_W-1:0];
				pins_d.ad_oe_n = 1'b0;
			end else if (cur_q.wr && (state_q != S_POST || el_q < xms_dhold_t(act_q))) begin
				pins_d.ad_out = cur_q.data;
				pins_d.ad_oe_n = 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pins_q <= XMS_PINS_IDLE;
			adr_q <= 1'b0;
			bea_q <= 1'b0;
		end else begin
			pins_q <= pins_d;
			adr_q <= adr_d;
			bea_q <= bea_d;
		end
	end

	// checking helpers: ticks since latch fell, latch width, strobe width, ticks since strobe rose
	logic [`XMS_CNT_W-1:0] since_q, since_d, alen_q, alen_d, slen_q, slen_d, rise_q, rise_d;
	logic strb_on;

	always_comb begin
		strb_on = !pins_q.wr_n || !pins_q.rd_n;
		since_d = pins_q.address_latch_enable ? `XMS_CNT_ZERO : since_q + `XMS_CNT_ONE;
		alen_d = pins_q.address_latch_enable ? alen_q + `XMS_CNT_ONE : `XMS_CNT_ZERO;
		slen_d = strb_on ? slen_q + `XMS_CNT_ONE : `XMS_CNT_ZERO;
		rise_d = strb_on ? `XMS_CNT_ZERO : rise_q + `XMS_CNT_ONE;
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			since_q <= `XMS_CNT_ZERO;
			alen_q <= `XMS_CNT_ZERO;
			slen_q <= `XMS_CNT_ZERO;
			rise_q <= `XMS_CNT_ZERO;
		end else begin
			since_q <= since_d;
			alen_q <= alen_d;
			slen_q <= slen_d;
			rise_q <= rise_d;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);

	a_ale_width: assert property ($fell(pins_q.address_latch_enable) |-> alen_q == xms_ale_t(act_q))
		else $error("latch enable width wrong");
	a_addr_hold: assert property ($fell(adr_q) |-> since_q == xms_hold_t(act_q))
		else $error("address hold after latch wrong");
	a_wr_delay: assert property ($fell(pins_q.wr_n) |-> since_q == xms_gap_t(act_q, 1'b1))
		else $error("write strobe start wrong");
	a_wr_width: assert property ($rose(pins_q.wr_n) |-> slen_q == xms_strb_t(act_q, 1'b1) && cur_q.wr)
		else $error("write strobe width wrong");
	a_wr_data_hold: assert property ($rose(pins_q.ad_oe_n) && cur_q.wr |-> rise_q == xms_dhold_t(act_q))
		else $error("write data hold wrong");
	a_wr_release: assert property ($rose(pins_q.memory_select_n) && cur_q.wr |-> rise_q == xms_post_t(act_q, 1'b1))
		else $error("select release after write wrong");
	a_rd_delay: assert property ($fell(pins_q.rd_n) |-> since_q == xms_gap_t(act_q, 1'b0) && !cur_q.wr)
		else $error("read strobe start wrong");
	a_rd_width: assert property ($rose(pins_q.rd_n) |-> slen_q == xms_strb_t(act_q, 1'b0) ##1 rval_q)
		else $error("read strobe width or capture wrong");
	a_sel_latch: assert property ($fell(pins_q.memory_select_n) |=> $rose(pins_q.address_latch_enable))
		else $error("latch not half clock after select");
	a_lane_start: assert property ($rose(bea_q) |-> since_q == `XMS_HALF && !pins_q.address_latch_enable)
		else $error("byte lanes not half clock after latch");
	a_rd_release: assert property ($rose(pins_q.rd_n) |-> !pins_q.memory_select_n ##1 !pins_q.memory_select_n
		##1 pins_q.memory_select_n)
		else $error("select release after read wrong");

	c_write: cover property ($rose(pins_q.wr_n));
	c_read: cover property ($rose(pins_q.rd_n) ##2 $rose(pins_q.memory_select_n));
	c_full: cover property (!cmd_ready);
	c_back_to_back: cover property ($rose(pins_q.memory_select_n) ##2 $fell(pins_q.memory_select_n));
endmodule : xms_seq
`default_nettype wire

// ---- testbench/xms_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "xms_defines.svh"
// far-side memory: latches the address, stores on write strobe, answers reads
module xms_mem_model (
	// clock
	input wire logic ref_clk,
	// memory pins
	input wire xms_pkg::xms_pins_t pins,
	output logic [`XMS_AD_W-1:0] ad_in
);
	import xms_pkg::*;
	logic [`XMS_AD_W-1:0] mem [0:15];
	logic [`XMS_AW-1:0] addr = '0;
	logic [`XMS_AD_W-1:0] drv = '0;
	logic hold = 1'b0;
	// one shared wire: the block wins while it drives
	assign ad_in = !pins.ad_oe_n ? pins.ad_out : drv;
	always @(posedge ref_clk) begin
		if (pins.address_latch_enable) begin
			addr <= {pins.addr_hi, pins.ad_out};
		end
		if (!pins.wr_n && !pins.memory_select_n && !pins.ad_oe_n) begin
			mem[addr[3:0]] <= pins.ad_out;
		end
		if (!pins.rd_n && !pins.memory_select_n) begin
			drv <= mem[addr[3:0]];
			hold <= 1'b1;
		end else if (hold) begin
			hold <= 1'b0;
		end else begin
			drv <= ~drv; // released: never a stale value
		end
	end
endmodule : xms_mem_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "xms_defines.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
	$display("[FAIL] t=%0t got %0h exp %0h", $time, (a), (b)); end end
module tb_top;
	import xms_pkg::*;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	xms_bus_t bus = '0;
	logic [`XMS_DW-1:0] rdata;
	logic cmd_ready;
	logic rdy_s;
	xms_pins_t pins;
	xms_pins_t pv = XMS_PINS_IDLE;
	logic [`XMS_AD_W-1:0] ad_in;
	int bad_count = 0;
	int compares = 0;
	int cyc = 0;
	int t_ar, t_af, t_mf, t_sf, t_sr, t_be, t_oe;
	int t_mr = -100;
	logic [17:0] t_adr;
	logic [1:0] t_lane;
	logic rd1 = 1'b0;
	logic [31:0] r;
	logic [14:0] cfgs [4] = '{15'h0000, 15'h7FFF, 15'h2523, 15'h5A5C};
	always #10 ref_clk = ~ref_clk;
	xms_seq xms_seq_inst (.ref_clk(ref_clk), .arst_n(arst_n), .bus(bus), .bus_rdata_q(rdata),
		.cmd_ready(cmd_ready), .pins_q(pins), .ad_in(ad_in));
	xms_mem_model xms_mem_model_inst (.ref_clk(ref_clk), .pins(pins), .ad_in(ad_in));
	// edge times of the memory pins, in ticks
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		pv <= pins;
		if (pins.address_latch_enable && !pv.address_latch_enable) t_ar <= cyc;
		if (!pins.address_latch_enable && pv.address_latch_enable) t_af <= cyc;
		if (!pins.memory_select_n && pv.memory_select_n) begin
			t_mf <= cyc;
			`CHK(cyc - t_mr >= 2, 1'b1)
		end
		if (pins.memory_select_n && !pv.memory_select_n) t_mr <= cyc;
		if ((pins.rd_n & pins.wr_n) < (pv.rd_n & pv.wr_n)) t_sf <= cyc;
		if ((pins.rd_n & pins.wr_n) > (pv.rd_n & pv.wr_n)) t_sr <= cyc;
		if (pins.byte_lane_enables_n != 2'h3 && pv.byte_lane_enables_n == 2'h3) t_be <= cyc;
		if (pins.ad_oe_n && !pv.ad_oe_n) t_oe <= cyc;
		if (pins.address_latch_enable) t_adr <= {pins.addr_hi, pins.ad_out};
		if (!pins.memory_select_n && pins.byte_lane_enables_n != 2'h3) t_lane <= pins.byte_lane_enables_n;
		// read data stands one cycle only, zero otherwise
		rd1 <= bus.rd;
		if (arst_n && !rd1) `CHK(rdata, 32'h0)
	end
	task automatic results();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : results
	// a gap cycle after each write keeps strobes from being set twice in one step
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge ref_clk);
		bus.wr <= 1'b0;
		@(posedge ref_clk);
	endtask : bus_wr
	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge ref_clk);
		bus.rd <= 1'b0;
		#1;
		d = rdata;
		rdy_s = cmd_ready;
		@(posedge ref_clk);
	endtask : bus_rd
	task automatic wait_idle();
		logic [31:0] s;
		repeat (4) @(posedge ref_clk);
		for (int i = 0; i < 2000; i++) begin
			bus_rd(`XMS_R_STAT, s);
			if (s[`XMS_ST_BUSY] === 1'b0 && s[`XMS_ST_EMPTY] === 1'b1) begin
				repeat (4) @(posedge ref_clk);
				return;
			end
		end
		bad_count++;
		results();
	endtask : wait_idle
	// one memory cycle; phase lengths judged from the configuration bits
	task automatic mem_cycle(input logic [14:0] c, input logic w, input logic [17:0] a,
		input logic [15:0] d);
		int n10, n8, n9, fs;
		logic [31:0] q;
		n10 = c[10] ? 0 : 2;
		n8 = c[8] ? 0 : 2;
		n9 = c[9] ? 0 : 2;
		fs = w ? c[7:4] : c[3:0];
		bus_wr(`XMS_R_CFG, {17'h0, c});
		bus_wr(`XMS_R_ADDR, {14'h0, a});
		bus_wr(`XMS_R_WDAT, {16'h0, w ? d : 16'h0});
		bus_wr(`XMS_R_CMD, {29'h0, 1'b1, a[0], w});
		wait_idle();
		`CHK(t_af - t_ar, 2 * (c[14:12] + 1))
		`CHK(t_ar - t_mf, 1)
		`CHK(t_be - t_af, 1)
		`CHK(t_sf - t_af, 1 + n10 + (w ? n8 : n9))
		`CHK(t_sr - t_sf, 2 * (fs + 1))
		`CHK(t_mr - t_sr, w ? n8 + 2 : 2)
		`CHK(t_oe - (w ? t_sr : t_af), w ? n8 : 1 + n10)
		`CHK(t_adr, a)
		`CHK(t_lane, ~{1'b1, a[0]})
		if (!w) begin
			bus_rd(`XMS_R_RDAT, q);
			`CHK(q, {16'h0, d})
		end
	endtask : mem_cycle
	task automatic regs_check();
		`CHK(pins, XMS_PINS_IDLE)
		`CHK(cmd_ready, 1'b1)
		bus_rd(`XMS_R_CFG, r);
		`CHK(r, 32'h0000_0000)
		bus_wr(`XMS_R_CFG, 32'hFFFF_FFFF);
		bus_rd(`XMS_R_CFG, r);
		`CHK(r, 32'h0000_7FFF)
		bus_rd(8'h20, r);
		`CHK(r, 32'h0000_0000)
	endtask : regs_check
	// queue filled past its depth while slow cycles stall the drain
	task automatic fill_check();
		bus_wr(`XMS_R_CFG, 32'h0000_7FFF);
		repeat (12) bus_wr(`XMS_R_CMD, 32'h0000_0007);
		bus_rd(`XMS_R_STAT, r);
		`CHK(r[`XMS_ST_FULL], 1'b1)
		`CHK(r[`XMS_ST_OVF], 1'b1)
		`CHK(rdy_s, 1'b0)
		bus_wr(`XMS_R_STAT, 32'h0000_0010);
		bus_rd(`XMS_R_STAT, r);
		`CHK(r[`XMS_ST_OVF], 1'b0)
		wait_idle();
		bus_rd(`XMS_R_STAT, r);
		`CHK(r[`XMS_ST_EMPTY], 1'b1)
	endtask : fill_check
	// reset dropped in mid-cycle: pins, queue and registers go back to reset values
	task automatic reset_check();
		bus_wr(`XMS_R_CFG, 32'h0000_7FFF);
		bus_wr(`XMS_R_CMD, 32'h0000_0007);
		repeat (6) @(posedge ref_clk);
		`CHK(pins.memory_select_n, 1'b0)
		arst_n <= 1'b0;
		@(posedge ref_clk);
		`CHK(pins, XMS_PINS_IDLE)
		`CHK(cmd_ready, 1'b1)
		arst_n <= 1'b1;
		@(posedge ref_clk);
		bus_rd(`XMS_R_CFG, r);
		`CHK(r, 32'h0000_0000)
		bus_rd(`XMS_R_STAT, r);
		`CHK(r, 32'h0000_0004)
	endtask : reset_check
	initial begin
		repeat (16) @(posedge ref_clk);
		arst_n <= 1'b1;
		@(posedge ref_clk);
		regs_check();
		for (int i = 0; i < 4; i++) begin
			mem_cycle(cfgs[i], 1'b1, 18'((i << 16) | i), 16'hA5C0 + 16'(i));
			mem_cycle(cfgs[i], 1'b0, 18'((i << 16) | i), 16'hA5C0 + 16'(i));
		end
		fill_check();
		reset_check();
		results();
	end
endmodule : tb_top
`default_nettype wire
